/* core/prmu_defs.svh */
// offsets, field positions and reset values for the paged relocation unit
`ifndef PRMU_DEFS_SVH
`define PRMU_DEFS_SVH

`define PRMU_KBASE_OFS 8'h00
`define PRMU_KDESC_OFS 8'h20
`define PRMU_UBASE_OFS 8'h40
`define PRMU_UDESC_OFS 8'h60
`define PRMU_CTRL_OFS 8'h80
`define PRMU_STAT_OFS 8'h84
`define PRMU_SET_BIT 6
`define PRMU_KIND_BIT 5
`define PRMU_CTRL_RELOC_BIT 0

`define PRMU_ACF_MSB 2
`define PRMU_ACF_LSB 1
`define PRMU_PLEN_MSB 14
`define PRMU_PLEN_LSB 8
`define PRMU_DESC_MASK 16'h7F06
`define PRMU_BASE_W 12
`define PRMU_BLK_SHIFT 6

`define PRMU_PSW_MODE_MSB 15
`define PRMU_PSW_MODE_LSB 14
`define PRMU_MODE_KERNEL 2'h0
`define PRMU_MODE_USER 2'h3
`define PRMU_IO_PAGE 3'h7
`define PRMU_IO_HIGH 2'h3

`define PRMU_ACF_NONRES 2'h0
`define PRMU_ACF_RDONLY 2'h1
`define PRMU_ACF_UNUSED 2'h2
`define PRMU_ACF_RDWR 2'h3

`define PRMU_BASE_RST 12'h000
`define PRMU_DESC_RST 16'h0000
`define PRMU_RELOC_RST 1'b0

`endif

/* core/prmu_pkg.sv */
// types shared by the paged relocation unit
package prmu_pkg;
    typedef enum logic [2:0] {
        PRMU_OK,
        PRMU_MODE,
        PRMU_NONRES,
        PRMU_LENGTH,
        PRMU_RDONLY
    } prmu_cause_t;
endpackage

/* core/prmu_top.sv */
// paged relocation unit: page registers, bus slave and processor request path
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "prmu_defs.svh"
module prmu_top
    import prmu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic [15:0] virtual_address,
    input wire logic [15:0] processor_status_word,
    input wire logic priv_instr,
    output logic bus_req,
    output logic bus_write,
    output logic [17:0] physical_address,
    output logic mmu_abort,
    output logic sp_select,
    output logic priv_refuse
);
    // [5] hit, [4] user set, [3] descriptor, [2:0] page
    function automatic logic [5:0] prmu_decode(input logic [7:0] a);
        logic [5:0] r;
        r = 6'h00;
        if (a < `PRMU_CTRL_OFS && a[1:0] == 2'h0) begin
            r = {1'b1, a[`PRMU_SET_BIT], a[`PRMU_KIND_BIT], a[4:2]};
        end
        return r;
    endfunction

    // every pair keeps its own rights, so aliased bases stay independent
    logic [11:0] base_mem [16];
    logic [15:0] desc_mem [16];
    logic reloc_en;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    prmu_cause_t last_cause;
    logic [15:0] abort_va;
    logic [17:0] xl_paddr;
    logic xl_abort;
    prmu_cause_t xl_cause;

    // hsize is not checked: only whole-word transfers are supported
    wire addr_take = hsel && hready && htrans[1];
    wire [5:0] wr_dec = prmu_decode(wr_addr);
    wire [5:0] rd_dec = prmu_decode(rd_addr);
    wire [3:0] wr_slot = {wr_dec[4], wr_dec[2:0]};
    wire [3:0] rd_slot = {rd_dec[4], rd_dec[2:0]};
    wire wr_base = wr_pend && wr_dec[5] && !wr_dec[3];
    wire wr_desc = wr_pend && wr_dec[5] && wr_dec[3];
    wire wr_ctrl = wr_pend && wr_addr == `PRMU_CTRL_OFS;
    wire wr_stat = wr_pend && wr_addr == `PRMU_STAT_OFS;

    wire [31:0] pair_word = rd_dec[3] ? {16'h0000, desc_mem[rd_slot]} :
        {20'h00000, base_mem[rd_slot]};
    wire [31:0] rd_word = rd_dec[5] ? pair_word :
        rd_addr == `PRMU_CTRL_OFS ? {31'h00000000, reloc_en} :
        rd_addr == `PRMU_STAT_OFS ? {abort_va, 13'h0000, last_cause} : 32'h00000000;

    wire [1:0] cur_mode = processor_status_word[`PRMU_PSW_MODE_MSB:`PRMU_PSW_MODE_LSB];
    wire user_mode = cur_mode == `PRMU_MODE_USER;
    wire [3:0] xl_slot = {user_mode, virtual_address[15:13]};

    prmu_xlate u_xlate (
        .reloc_en(reloc_en),
        .mode(cur_mode),
        .vaddr(virtual_address),
        .write(cpu_write),
        .page_base(base_mem[xl_slot]),
        .page_desc(desc_mem[xl_slot]),
        .paddr(xl_paddr),
        .abort(xl_abort),
        .cause(xl_cause)
    );

    // bus slave: writes land in the data phase, reads take one wait state so that
    // a read right behind a write already sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= addr_take && hwrite;
            rd_pend <= addr_take && !hwrite;
            if (addr_take) begin
                wr_addr <= haddr[7:0];
                rd_addr <= haddr[7:0];
            end
            hreadyout <= !(addr_take && !hwrite);
            hresp <= 1'b0;
            if (rd_pend) begin
                hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++) begin
                base_mem[i] <= `PRMU_BASE_RST;
                desc_mem[i] <= `PRMU_DESC_RST;
            end
        end else begin
            if (wr_base) begin
                base_mem[wr_slot] <= hwdata[`PRMU_BASE_W-1:0];
            end
            if (wr_desc) begin
                desc_mem[wr_slot] <= hwdata[15:0] & `PRMU_DESC_MASK;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reloc_en <= `PRMU_RELOC_RST;
        end else if (wr_ctrl) begin
            reloc_en <= hwdata[`PRMU_CTRL_RELOC_BIT];
        end
    end

    // a new abort in the cycle of a status write wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_cause <= PRMU_OK;
            abort_va <= 16'h0000;
        end else if (cpu_req && xl_abort) begin
            last_cause <= xl_cause;
            abort_va <= virtual_address;
        end else if (wr_stat) begin
            last_cause <= PRMU_OK;
        end
    end

    // one request per cycle, answered one edge later; an abort never reaches the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            physical_address <= 18'h00000;
            mmu_abort <= 1'b0;
            sp_select <= 1'b0;
            priv_refuse <= 1'b0;
        end else begin
            bus_req <= cpu_req && !xl_abort;
            mmu_abort <= cpu_req && xl_abort;
            if (cpu_req && !xl_abort) begin
                physical_address <= xl_paddr;
                bus_write <= cpu_write;
            end
            sp_select <= user_mode;
            priv_refuse <= priv_instr && cur_mode != `PRMU_MODE_KERNEL;
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire [1:0] sel_acf = desc_mem[xl_slot][`PRMU_ACF_MSB:`PRMU_ACF_LSB];
    wire [6:0] sel_len = desc_mem[xl_slot][`PRMU_PLEN_MSB:`PRMU_PLEN_LSB];
    wire [17:0] sel_sum = {base_mem[xl_slot], 6'h00} + {5'h00, virtual_address[12:0]};
    wire good_mode = cur_mode == `PRMU_MODE_KERNEL || user_mode;

    a_abort_blocks_bus: assert property (mmu_abort |-> !bus_req)
        else $error("abort and bus request together");
    a_req_answered: assert property (cpu_req |=> (bus_req != mmu_abort))
        else $error("request not answered in one cycle");
    a_io_passthru: assert property (cpu_req && !reloc_en && good_mode &&
        virtual_address[15:13] == `PRMU_IO_PAGE |=> bus_req &&
        physical_address == {`PRMU_IO_HIGH, $past(virtual_address)})
        else $error("io page not forced high");
    a_low_passthru: assert property (cpu_req && !reloc_en && good_mode &&
        virtual_address[15:13] != `PRMU_IO_PAGE |=> bus_req &&
        physical_address == {2'h0, $past(virtual_address)})
        else $error("low address altered without relocation");
    a_bad_mode: assert property (cpu_req && !good_mode |=> mmu_abort && !bus_req)
        else $error("illegal mode not aborted");
    a_read_only: assert property (cpu_req && reloc_en && good_mode && cpu_write &&
        sel_acf == `PRMU_ACF_RDONLY |=> mmu_abort)
        else $error("write to read-only page passed");
    a_nonresident: assert property (cpu_req && reloc_en && (sel_acf == `PRMU_ACF_NONRES ||
        sel_acf == `PRMU_ACF_UNUSED) |=> mmu_abort)
        else $error("non-resident page reached");
    a_page_length: assert property (cpu_req && reloc_en &&
        virtual_address[12:6] > sel_len |=> mmu_abort)
        else $error("reference beyond page length passed");
    a_reloc_sum: assert property (cpu_req && reloc_en && good_mode &&
        sel_acf == `PRMU_ACF_RDWR && virtual_address[12:6] <= sel_len
        |=> bus_req && physical_address == $past(sel_sum))
        else $error("relocated address wrong");
    a_stack_mode: assert property (user_mode |=> sp_select)
        else $error("stack select not following user mode");
    a_priv_user: assert property (priv_instr && user_mode |=> priv_refuse)
        else $error("privileged instruction allowed in user mode");
    a_read_wait: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_reloc_ok: cover property (cpu_req && reloc_en && !xl_abort ##1 bus_req);
    c_io_page: cover property (cpu_req && !reloc_en && virtual_address[15:13] == 3'h7);
    c_rdonly_abort: cover property (cpu_req && xl_cause == PRMU_RDONLY ##1 mmu_abort);
    c_bus_read: cover property (addr_take && !hwrite ##2 hreadyout);
endmodule
`default_nettype wire

/* core/prmu_xlate.sv */
// virtual to physical translation and access check for one page register pair
`timescale 1ns/1ps
`default_nettype none
`include "prmu_defs.svh"
module prmu_xlate
    import prmu_pkg::*;
(
    input wire logic reloc_en,
    input wire logic [1:0] mode,
    input wire logic [15:0] vaddr,
    input wire logic write,
    input wire logic [11:0] page_base,
    input wire logic [15:0] page_desc,
    output logic [17:0] paddr,
    output logic abort,
    output var prmu_cause_t cause
);
    wire [1:0] acf = page_desc[`PRMU_ACF_MSB:`PRMU_ACF_LSB];
    wire [6:0] plen = page_desc[`PRMU_PLEN_MSB:`PRMU_PLEN_LSB];
    wire [6:0] blk = vaddr[12:`PRMU_BLK_SHIFT];
    wire io_page = vaddr[15:13] == `PRMU_IO_PAGE;
    wire mode_bad = mode != `PRMU_MODE_KERNEL && mode != `PRMU_MODE_USER;
    wire nonres = acf == `PRMU_ACF_NONRES || acf == `PRMU_ACF_UNUSED;
    wire too_long = blk > plen;
    wire rd_only = write && acf == `PRMU_ACF_RDONLY;
    // base sits on a 32-word boundary, so the low six byte bits come from the offset
    wire [17:0] reloc_pa = {page_base, 6'h00} + {5'h00, vaddr[12:0]};
    wire [17:0] direct_pa = {(io_page ? `PRMU_IO_HIGH : 2'h0), vaddr};

    assign paddr = reloc_en ? reloc_pa : direct_pa;
    assign abort = cause != PRMU_OK;

    always_comb begin
        cause = PRMU_OK;
        if (mode_bad) begin
            cause = PRMU_MODE;
        end else if (reloc_en && nonres) begin
            cause = PRMU_NONRES;
        end else if (reloc_en && too_long) begin
            cause = PRMU_LENGTH;
        end else if (reloc_en && rd_only) begin
            cause = PRMU_RDONLY;
        end
    end
endmodule
`default_nettype wire

/* dv/prmu_mem_model.sv */
// system bus memory stand-in: counts the cycles that reach it
`timescale 1ns/1ps
`default_nettype none
module prmu_mem_model (
    input wire logic hclk,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [17:0] physical_address,
    output logic [15:0] cycles,
    output logic [17:0] last_addr,
    output logic last_write
);
    initial begin
        cycles = 16'h0000;
        last_addr = 18'h00000;
        last_write = 1'b0;
    end
    // only a passed reference may start a memory cycle; aborts must leave this untouched
    always @(posedge hclk) begin
        if (bus_req === 1'b1) begin
            cycles <= cycles + 16'h0001;
            last_addr <= physical_address;
            last_write <= bus_write;
        end
    end
endmodule
`default_nettype wire

/* dv/prmu_top_bench.sv */
// self-checking testbench for the paged relocation unit
`timescale 1ns/1ps
`default_nettype none
module prmu_top_bench;
    import prmu_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, bus_req, bus_write, mmu_abort, sp_select, priv_refuse, last_write;
    logic [31:0] hrdata;
    logic cpu_req = 1'b0;
    logic cpu_write = 1'b0;
    logic [15:0] virtual_address = 16'h0000;
    logic [15:0] processor_status_word = 16'h0000;
    logic priv_instr = 1'b0;
    logic [17:0] physical_address, last_addr;
    logic [15:0] cycles;
    logic [31:0] d;
    int bad_count = 0;
    int samples_checked = 0;

    always #12.5 hclk = ~hclk;

    prmu_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cpu_req(cpu_req), .cpu_write(cpu_write), .virtual_address(virtual_address),
        .processor_status_word(processor_status_word), .priv_instr(priv_instr),
        .bus_req(bus_req), .bus_write(bus_write), .physical_address(physical_address),
        .mmu_abort(mmu_abort), .sp_select(sp_select), .priv_refuse(priv_refuse));

    prmu_mem_model mem (.hclk(hclk), .bus_req(bus_req), .bus_write(bus_write),
        .physical_address(physical_address), .cycles(cycles), .last_addr(last_addr),
        .last_write(last_write));

    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // hreadyout is registered, so right after the edge it still shows the sampled value
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        haddr <= {24'h000000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        wait_rdy();
    endtask

    task automatic ahb_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        haddr <= {24'h000000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_rdy();
        v = hrdata;
    endtask

    // one processor reference; mode stays applied afterwards for the stack select checks
    task automatic cref(input logic [15:0] va, input logic wr, input logic [1:0] md,
        input logic ab, input logic [17:0] pa);
        logic [15:0] c0;
        c0 = cycles;
        @(posedge hclk);
        cpu_req <= 1'b1;
        cpu_write <= wr;
        virtual_address <= va;
        processor_status_word <= {md, 14'h0000};
        @(posedge hclk);
        cpu_req <= 1'b0;
        #1;
        chk({31'h0, mmu_abort}, {31'h0, ab});
        chk({31'h0, bus_req}, {31'h0, ~ab});
        if (!ab) chk({14'h0, physical_address}, {14'h0, pa});
        if (!ab) chk({31'h0, bus_write}, {31'h0, wr});
        @(posedge hclk);
        #1;
        chk({16'h0, cycles}, {16'h0, c0 + {15'h0, ~ab}});
    endtask

    task automatic priv_try(input logic exp);
        @(posedge hclk);
        priv_instr <= 1'b1;
        @(posedge hclk);
        priv_instr <= 1'b0;
        #1;
        chk({31'h0, priv_refuse}, {31'h0, exp});
    endtask

    function automatic logic [31:0] desc(input logic [6:0] len, input logic [1:0] acf);
        return {17'h0, len, 5'h00, acf, 1'b0};
    endfunction

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb_rd(8'h80, d);
        chk(d, 32'h0);
        ahb_rd(8'h34, d);
        chk(d, 32'h0);
        ahb_wr(8'h04, 32'hFFFF_F123);
        ahb_rd(8'h04, d);
        chk(d, 32'h0000_0123);
        ahb_rd(8'hF0, d);
        chk(d, 32'h0);
        cref(16'hE004, 1'b0, 2'h0, 1'b0, 18'h3E004);
        cref(16'h1234, 1'b1, 2'h0, 1'b0, 18'h01234);
        cref(16'h0000, 1'b0, 2'h1, 1'b1, 18'h0);
        ahb_rd(8'h84, d);
        chk(d, 32'h0000_0001);
        cref(16'h0000, 1'b0, 2'h2, 1'b1, 18'h0);
        ahb_wr(8'h00, 32'h064);
        ahb_wr(8'h20, desc(7'h7F, 2'h3));
        ahb_wr(8'h04, 32'hFFF);
        ahb_wr(8'h24, desc(7'h7F, 2'h3));
        ahb_wr(8'h0C, 32'h010);
        ahb_wr(8'h2C, desc(7'h02, 2'h3));
        ahb_wr(8'h40, 32'h064);
        ahb_wr(8'h60, desc(7'h7F, 2'h1));
        ahb_wr(8'h80, 32'h1);
        cref(16'h0002, 1'b0, 2'h0, 1'b0, 18'h01902);
        cref(16'h2000, 1'b1, 2'h0, 1'b0, 18'h3FFC0);
        cref(16'h3FFE, 1'b0, 2'h0, 1'b0, 18'h01FBE);
        cref(16'h60BE, 1'b0, 2'h0, 1'b0, 18'h004BE);
        cref(16'h60C0, 1'b0, 2'h0, 1'b1, 18'h0);
        ahb_rd(8'h84, d);
        chk(d, 32'h60C0_0003);
        for (int a = 0; a < 4; a++) begin
            ahb_wr(8'h28, desc(7'h7F, 2'(a)));
            cref(16'h4010, 1'b0, 2'h0, a[0] == 1'b0, 18'h00010);
            cref(16'h4010, 1'b1, 2'h0, a != 3, 18'h00010);
        end
        cref(16'h0010, 1'b0, 2'h3, 1'b0, 18'h01910);
        chk({31'h0, sp_select}, 32'h1);
        priv_try(1'b1);
        cref(16'h0010, 1'b1, 2'h3, 1'b1, 18'h0);
        cref(16'hC000, 1'b0, 2'h3, 1'b1, 18'h0);
        cref(16'h0010, 1'b1, 2'h0, 1'b0, 18'h01910);
        chk({31'h0, sp_select}, 32'h0);
        chk({31'h0, last_write}, 32'h1);
        priv_try(1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
